/* verilog/lcm_defs.vh */
// Constants for the local connection memory decoder and its register port.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef LCM_DEFS_VH
`define LCM_DEFS_VH

// Register offsets on the processor port.
`define ABR_OFS 8'h0c
`define DWR_OFS 8'h0d
`define DRR_OFS 8'h0e
`define CTRL_OFS 8'h0f

// Reset values.
`define ABR_RST 16'h0000
`define DWR_RST 16'h0000
`define DRR_RST 16'h0000
`define MODE_RST 3'h0

// Address buffer register fields.
`define ABR_CDA 14
`define ABR_RS 13
`define ABR_WS 12
`define ABR_CH_HI 11
`define ABR_CH_LO 5
`define ABR_STR_HI 4
`define ABR_STR_LO 0

// Control register fields.
`define CTRL_MODE_HI 2
`define CTRL_MODE_LO 0
`define CTRL_HIGH_SEL 3

// Connection entry fields (low part).
`define ENT_LB 15
`define ENT_DLY 14
`define ENT_MSG 13
`define ENT_OE 12
`define ENT_STR_HI 11
`define ENT_STR_LO 7
`define ENT_CH_HI 6
`define ENT_CH_LO 0
`define ENT_BYTE_HI 7
`define ENT_BYTE_LO 0

// Connection entry fields (high part).
`define SUB_SEL_HI 1
`define SUB_SEL_LO 0

// Rate modes.
`define MODE_2M 3'h0
`define MODE_4M 3'h1
`define MODE_8M 3'h2
`define MODE_HMVIP 3'h3
`define MODE_SUB 3'h4

// System clocks per serial bit for each rate at 50 MHz (nearest whole count).
`define DIV_2M 8'h18
`define DIV_4M 8'h0c
`define DIV_8M 8'h06

// Last channel index per frame, equal to the channel field mask.
`define LAST_CH_32 7'h1f
`define LAST_CH_64 7'h3f
`define LAST_CH_128 7'h7f

// Highest legal source stream number per side and rate.
`define LAST_LS_2M 5'h0f
`define LAST_LS_8M 5'h03
`define LAST_LS_SUB 5'h0c
`define LAST_LS_NONE 5'h00
`define LAST_BS_32 5'h1f
`define LAST_BS_8M 5'h0f
`define LAST_BS_HMVIP 5'h17

// Fill values and the last bit index of a slot.
`define IDLE_BYTE 8'hff
`define SUB_PAD 6'h3f
`define LAST_BIT 3'h7

`endif

/* verilog/lcm_fifo.v */
// Synchronous FIFO with valid/ready handshakes on both sides.
// Assumes one clock and an asynchronous active-low reset; DEPTH is a power of two.
module lcm_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 32,
	parameter AW = 5
)(
	input wire clk_sys,
	input wire arst_n,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wr_ptr_ff;
	reg [AW:0] rd_ptr_ff;
	wire push;
	wire pop;

	// Full when the pointers differ only in the wrap bit; empty when equal.
	assign in_ready = (wr_ptr_ff ^ rd_ptr_ff) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_ptr_ff != rd_ptr_ff;
	assign out_data = mem[rd_ptr_ff[AW-1:0]];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Storage carries no reset; only the pointers define content.
	always @(posedge clk_sys)
	begin
		if (push)
			mem[wr_ptr_ff[AW-1:0]] <= in_data;
	end

	// Pointer update.
	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_ptr_ff <= {(AW+1){1'b0}};
			rd_ptr_ff <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
		end
	end

endmodule

/* verilog/lcm_decode.v */
// Local connection memory decoder: per-channel entries steer sixteen local serial outputs.
// Assumes the processor port is synchronous to CLK_SYS and serial pins are asynchronous.
//
// Notes on behaviour
// [RULE1] Select bit one takes a local input stream.
// [RULE2] Select bit zero takes a backplane stream.
// [RULE3] Delay bit picks variable or constant delay.
// [RULE4] Message bit outputs entry contents, not switched data.
// [RULE5] Message mode sends only the entry low byte.
// [RULE6] Otherwise entry addresses switched source data.
// [RULE7] Output enable bit drives or floats the slot.
// [RULE8] Bits eleven to seven name source stream.
// [RULE9] Bits six to zero name source channel.
// [RULE10] Message byte is stream bit zero plus channel.
// [RULE11] Legal stream range depends on rate mode.
// [RULE12] Channel field width follows the data rate.
// [RULE13] Software keeps high part bits fifteen to two zero.
// [RULE14] Two-bit field picks the sub-rate bit pair.
// [RULE15] Read select rise loads data read register.
// [RULE16] Write select rise stores write data register.
// [RULE17] Completion flag clears when software drops select.
// [RULE18] Each entry is read once per frame slot.
`include "lcm_defs.vh"

module lcm_decode #(
	parameter LSTREAMS = 16,
	parameter BSTREAMS = 32,
	parameter CHANNELS = 128,
	parameter FIFO_DEPTH = 32
)(
	input wire CLK_SYS,
	input wire ARST_N,
	input wire [7:0] CPU_ADDR,
	input wire [15:0] CPU_WDATA,
	input wire CPU_WR,
	input wire CPU_RD,
	output reg [15:0] CPU_RDATA,
	output reg CPU_ACK,
	input wire [15:0] LOCAL_SERIAL_INPUTS,
	input wire [31:0] BACKPLANE_SERIAL_LINES,
	output reg [15:0] LOCAL_SERIAL_OUTPUTS,
	output reg [15:0] LOCAL_SERIAL_OE,
	output reg FRAME_START
);

	////////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// Clocks per serial bit for the selected rate.
	function [7:0] bit_div;
		input [2:0] mode;
		begin
			case (mode)
				`MODE_4M: bit_div = `DIV_4M;
				`MODE_8M: bit_div = `DIV_8M;
				`MODE_HMVIP: bit_div = `DIV_8M;
				default: bit_div = `DIV_2M;
			endcase
		end
	endfunction

	// Last channel of the frame, also the mask on the source channel field.
	function [6:0] last_ch;
		input [2:0] mode;
		begin
			case (mode)
				`MODE_4M: last_ch = `LAST_CH_64;
				`MODE_8M: last_ch = `LAST_CH_128;
				`MODE_HMVIP: last_ch = `LAST_CH_128;
				default: last_ch = `LAST_CH_32;
			endcase
		end
	endfunction

	// Local data memory index: bank, stream, channel.
	function [11:0] lidx;
		input bank;
		input [4:0] str;
		input [6:0] ch;
		begin
			lidx = {bank, str[3:0], ch};
		end
	endfunction

	// Backplane data memory index: bank, stream, channel.
	function [12:0] bidx;
		input bank;
		input [4:0] str;
		input [6:0] ch;
		begin
			bidx = {bank, str, ch};
		end
	endfunction

	// Next channel with wrap at the end of the frame.
	function [6:0] ch_inc;
		input [6:0] ch;
		input [6:0] last;
		begin
			ch_inc = (ch == last) ? 7'h00 : ch + 7'h01;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Storage.

	reg [15:0] lcm_lo [0:LSTREAMS*CHANNELS-1];
	reg [1:0] lcm_hi [0:LSTREAMS*CHANNELS-1];
	reg [7:0] ldat [0:2*LSTREAMS*CHANNELS-1];
	reg [7:0] bdat [0:2*BSTREAMS*CHANNELS-1];
	reg [7:0] lsh [0:LSTREAMS-1];
	reg [7:0] bsh [0:BSTREAMS-1];
	reg [7:0] osh [0:LSTREAMS-1];
	reg [7:0] stg [0:LSTREAMS-1];
	reg [LSTREAMS-1:0] stg_oe_ff;

	// Registers and timing state.
	reg [2:0] mode_ff;
	reg high_sel_ff;
	reg [6:0] abr_ch_ff;
	reg [4:0] abr_str_ff;
	reg rs_ff;
	reg ws_ff;
	reg cda_ff;
	reg sw_rs_ff;
	reg sw_ws_ff;
	reg [15:0] dwr_ff;
	reg [15:0] drr_ff;
	reg [7:0] div_cnt_ff;
	reg [2:0] bit_idx_ff;
	reg [6:0] ch_ff;
	reg frame_par_ff;
	reg dec_active_ff;
	reg [3:0] dec_str_ff;
	reg [6:0] dec_ch_ff;
	reg [4:0] stg_cnt_ff;
	reg [15:0] lin_s1_ff;
	reg [15:0] lin_s2_ff;
	reg [31:0] bin_s1_ff;
	reg [31:0] bin_s2_ff;
	localparam [15:0] abr_rst = `ABR_RST;

	wire bit_en;
	wire slot_end;
	wire [6:0] nxt_ch;
	wire [10:0] cpu_idx;
	wire abr_wr;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire fifo_out_ready;
	wire [8:0] fifo_out_data;
	wire [8:0] dec_word;
	integer i;
	integer j;
	integer k;

	assign bit_en = (div_cnt_ff == bit_div(mode_ff) - 8'h01);
	assign slot_end = bit_en && (bit_idx_ff == `LAST_BIT);
	assign nxt_ch = ch_inc(ch_ff, last_ch(mode_ff));
	assign cpu_idx = {abr_str_ff[3:0], abr_ch_ff};
	assign abr_wr = CPU_WR && (CPU_ADDR == `ABR_OFS);

	////////////////////////////////////////////////////////////////////////////
	// Processor port and indirect memory access.

	// The transfer engine runs after the port write so that its completion wins.
	always @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			mode_ff <= `MODE_RST;
			high_sel_ff <= 1'b0;
			abr_ch_ff <= abr_rst[`ABR_CH_HI:`ABR_CH_LO];
			abr_str_ff <= abr_rst[`ABR_STR_HI:`ABR_STR_LO];
			rs_ff <= 1'b0;
			ws_ff <= 1'b0;
			cda_ff <= 1'b0;
			sw_rs_ff <= 1'b0;
			sw_ws_ff <= 1'b0;
			dwr_ff <= `DWR_RST;
			drr_ff <= `DRR_RST;
		end
		else
		begin
			if (CPU_WR && CPU_ADDR == `CTRL_OFS)
			begin
				mode_ff <= CPU_WDATA[`CTRL_MODE_HI:`CTRL_MODE_LO];
				high_sel_ff <= CPU_WDATA[`CTRL_HIGH_SEL];
			end
			if (CPU_WR && CPU_ADDR == `DWR_OFS)
				dwr_ff <= CPU_WDATA;
			if (abr_wr)
			begin
				abr_ch_ff <= CPU_WDATA[`ABR_CH_HI:`ABR_CH_LO];
				abr_str_ff <= CPU_WDATA[`ABR_STR_HI:`ABR_STR_LO];
				sw_rs_ff <= CPU_WDATA[`ABR_RS];
				sw_ws_ff <= CPU_WDATA[`ABR_WS];
				if (CPU_WDATA[`ABR_RS] && !sw_rs_ff)
					rs_ff <= 1'b1; // [RULE15]
				if (CPU_WDATA[`ABR_WS] && !sw_ws_ff)
					ws_ff <= 1'b1; // [RULE16]
				if ((sw_rs_ff && !CPU_WDATA[`ABR_RS]) || (sw_ws_ff && !CPU_WDATA[`ABR_WS]))
					cda_ff <= 1'b0; // [RULE17]
			end
			// A pending read is served first; a write waits one cycle behind it.
			if (rs_ff)
			begin
				drr_ff <= high_sel_ff ? {14'h0000, lcm_hi[cpu_idx]} : lcm_lo[cpu_idx]; // [RULE15]
				rs_ff <= 1'b0;
				cda_ff <= 1'b1;
			end
			else if (ws_ff)
			begin
				ws_ff <= 1'b0; // [RULE16]
				cda_ff <= 1'b1;
			end
		end
	end

	// Connection memory write; only the two select bits of the high part are kept. [RULE13]
	always @(posedge CLK_SYS)
	begin
		if (ws_ff && !rs_ff)
		begin
			if (high_sel_ff)
				lcm_hi[cpu_idx] <= dwr_ff[`SUB_SEL_HI:`SUB_SEL_LO];
			else
				lcm_lo[cpu_idx] <= dwr_ff; // [RULE16]
		end
	end

	// Read data and acknowledge are registered; unmapped offsets read zero.
	always @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			CPU_RDATA <= 16'h0000;
			CPU_ACK <= 1'b0;
		end
		else
		begin
			CPU_ACK <= CPU_WR | CPU_RD;
			if (CPU_RD)
			begin
				case (CPU_ADDR)
					`ABR_OFS: CPU_RDATA <= {1'b0, cda_ff, rs_ff, ws_ff, abr_ch_ff, abr_str_ff};
					`DWR_OFS: CPU_RDATA <= dwr_ff;
					`DRR_OFS: CPU_RDATA <= drr_ff;
					`CTRL_OFS: CPU_RDATA <= {12'h000, high_sel_ff, mode_ff};
					default: CPU_RDATA <= 16'h0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Frame timing and input capture.

	// Bit divider, bit counter and channel slot counter.
	always @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			div_cnt_ff <= 8'h00;
			bit_idx_ff <= 3'h0;
			ch_ff <= 7'h00;
			frame_par_ff <= 1'b0;
			FRAME_START <= 1'b0;
			lin_s1_ff <= 16'h0000;
			lin_s2_ff <= 16'h0000;
			bin_s1_ff <= 32'h00000000;
			bin_s2_ff <= 32'h00000000;
		end
		else
		begin
			lin_s1_ff <= LOCAL_SERIAL_INPUTS;
			lin_s2_ff <= lin_s1_ff;
			bin_s1_ff <= BACKPLANE_SERIAL_LINES;
			bin_s2_ff <= bin_s1_ff;
			div_cnt_ff <= bit_en ? 8'h00 : div_cnt_ff + 8'h01;
			FRAME_START <= slot_end && (nxt_ch == 7'h00);
			if (bit_en)
				bit_idx_ff <= bit_idx_ff + 3'h1;
			if (slot_end)
			begin
				ch_ff <= nxt_ch;
				if (nxt_ch == 7'h00)
					frame_par_ff <= ~frame_par_ff;
			end
		end
	end

	// Input shifters feed the data memory bank of the current frame at each slot end.
	always @(posedge CLK_SYS)
	begin
		if (bit_en)
		begin
			for (i = 0; i < LSTREAMS; i = i + 1)
				lsh[i] <= {lsh[i][6:0], lin_s2_ff[i]};
			for (i = 0; i < BSTREAMS; i = i + 1)
				bsh[i] <= {bsh[i][6:0], bin_s2_ff[i]};
		end
		if (slot_end)
		begin
			for (i = 0; i < LSTREAMS; i = i + 1)
				ldat[lidx(frame_par_ff, i[4:0], ch_ff)] <= {lsh[i][6:0], lin_s2_ff[i]};
			for (i = 0; i < BSTREAMS; i = i + 1)
				bdat[bidx(frame_par_ff, i[4:0], ch_ff)] <= {bsh[i][6:0], bin_s2_ff[i]};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Entry decode.

	reg [15:0] ent_lo;
	reg [1:0] ent_hi;
	reg [4:0] src_str;
	reg [6:0] src_ch;
	reg [4:0] lim;
	reg bank;
	reg [7:0] src_byte;
	reg [7:0] out_byte;

	// One entry per output stream per slot, read while the slot before it runs.
	always @*
	begin
		ent_lo = lcm_lo[{dec_str_ff, dec_ch_ff}]; // [RULE18]
		ent_hi = lcm_hi[{dec_str_ff, dec_ch_ff}];
		src_str = ent_lo[`ENT_STR_HI:`ENT_STR_LO]; // [RULE8]
		src_ch = ent_lo[`ENT_CH_HI:`ENT_CH_LO] & last_ch(mode_ff); // [RULE9] [RULE12]
		bank = ent_lo[`ENT_DLY] ? ~frame_par_ff : frame_par_ff; // [RULE3]
		if (ent_lo[`ENT_LB])
		begin
			case (mode_ff)
				`MODE_2M: lim = `LAST_LS_2M;
				`MODE_8M: lim = `LAST_LS_8M;
				`MODE_SUB: lim = `LAST_LS_SUB;
				default: lim = `LAST_LS_NONE;
			endcase
		end
		else
		begin
			case (mode_ff)
				`MODE_8M: lim = `LAST_BS_8M;
				`MODE_HMVIP: lim = `LAST_BS_HMVIP;
				default: lim = `LAST_BS_32;
			endcase
		end
		// Local sources exist only at the local rates; out-of-range streams send idle. [RULE11]
		if (src_str > lim || (ent_lo[`ENT_LB] && (mode_ff == `MODE_4M || mode_ff == `MODE_HMVIP)))
			src_byte = `IDLE_BYTE;
		else if (ent_lo[`ENT_LB])
			src_byte = ldat[lidx(bank, src_str, src_ch)]; // [RULE1] [RULE6]
		else
			src_byte = bdat[bidx(bank, src_str, src_ch)]; // [RULE2] [RULE6]
		if (ent_lo[`ENT_MSG])
			out_byte = ent_lo[`ENT_BYTE_HI:`ENT_BYTE_LO]; // [RULE4] [RULE5] [RULE10]
		else if (mode_ff == `MODE_SUB)
		begin
			case (ent_hi)
				2'h3: out_byte = {`SUB_PAD, src_byte[7:6]}; // [RULE14]
				2'h2: out_byte = {`SUB_PAD, src_byte[5:4]};
				2'h1: out_byte = {`SUB_PAD, src_byte[3:2]};
				default: out_byte = {`SUB_PAD, src_byte[1:0]};
			endcase
		end
		else
			out_byte = src_byte;
	end

	assign dec_word = {ent_lo[`ENT_OE], out_byte};

	// Decoder walks the output streams and stalls while the FIFO is full.
	always @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			dec_active_ff <= 1'b0;
			dec_str_ff <= 4'h0;
			dec_ch_ff <= 7'h00;
		end
		else if (slot_end)
		begin
			dec_active_ff <= 1'b1; // [RULE18]
			dec_str_ff <= 4'h0;
			dec_ch_ff <= ch_inc(nxt_ch, last_ch(mode_ff));
		end
		else if (dec_active_ff && fifo_in_ready)
		begin
			dec_str_ff <= dec_str_ff + 4'h1;
			if (dec_str_ff == LSTREAMS[3:0] - 4'h1)
				dec_active_ff <= 1'b0;
		end
	end

	lcm_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH),
		.AW(5)
	) u_fifo (
		.clk_sys(CLK_SYS),
		.arst_n(ARST_N),
		.in_valid(dec_active_ff),
		.in_ready(fifo_in_ready),
		.in_data(dec_word),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Output staging and serialisers.

	// Staging is held at the slot boundary so a pop never races the load.
	assign fifo_out_ready = (stg_cnt_ff < LSTREAMS[4:0]) && !slot_end;

	// Staging fills from the FIFO; at slot end it moves to the shifters.
	always @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			stg_cnt_ff <= 5'h00;
			stg_oe_ff <= 16'h0000;
			LOCAL_SERIAL_OUTPUTS <= 16'hffff;
			LOCAL_SERIAL_OE <= 16'h0000;
		end
		else if (slot_end)
		begin
			stg_cnt_ff <= 5'h00;
			LOCAL_SERIAL_OE <= stg_oe_ff; // [RULE7]
			for (j = 0; j < LSTREAMS; j = j + 1)
				LOCAL_SERIAL_OUTPUTS[j] <= stg[j][7];
		end
		else
		begin
			if (fifo_out_valid && fifo_out_ready)
			begin
				stg_cnt_ff <= stg_cnt_ff + 5'h01;
				stg_oe_ff[stg_cnt_ff[3:0]] <= fifo_out_data[8];
			end
			if (bit_en)
				for (j = 0; j < LSTREAMS; j = j + 1)
					LOCAL_SERIAL_OUTPUTS[j] <= osh[j][6];
		end
	end

	// Byte storage for staging and shifting; MSB leaves first.
	always @(posedge CLK_SYS)
	begin
		if (fifo_out_valid && fifo_out_ready)
			stg[stg_cnt_ff[3:0]] <= fifo_out_data[7:0];
		for (k = 0; k < LSTREAMS; k = k + 1)
		begin
			if (slot_end)
				osh[k] <= stg[k];
			else if (bit_en)
				osh[k] <= {osh[k][6:0], 1'b1};
		end
	end

endmodule

/* sim/lcm_decode_sva.sv */
// Checker for the connection memory decoder: register port handshake and frame timing.
// Assumes it is bound to the decoder and sees only its ports.
module lcm_decode_chk (
	input logic CLK_SYS,
	input logic ARST_N,
	input logic [7:0] CPU_ADDR,
	input logic [15:0] CPU_WDATA,
	input logic CPU_WR,
	input logic CPU_RD,
	input logic [15:0] CPU_RDATA,
	input logic CPU_ACK,
	input logic FRAME_START
);
	logic [1:0] sel_ff;
	logic hsel_ff;
	logic seen_ff;
	logic [12:0] gap_ff;
	logic abr_wr;
	logic abr_rd;
	logic ctl_wr;
	logic sel_go;
	logic sel_drop;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!ARST_N);

	////////////////////////////////
	// Select edges are judged against the last value software wrote.
	assign abr_wr = CPU_WR && CPU_ADDR == 8'h0c;
	assign abr_rd = CPU_RD && !CPU_WR && CPU_ADDR == 8'h0c;
	assign ctl_wr = CPU_WR && CPU_ADDR == 8'h0f;
	assign sel_go = abr_wr && |(CPU_WDATA[13:12] & ~sel_ff);
	assign sel_drop = abr_wr && |(~CPU_WDATA[13:12] & sel_ff);

	// A rate change may leave one odd frame, so the gap check waits for a fresh pulse.
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			sel_ff <= 2'h0;
			hsel_ff <= 1'b0;
			seen_ff <= 1'b0;
			gap_ff <= 13'h0000;
		end
		else
		begin
			if (abr_wr)
				sel_ff <= CPU_WDATA[13:12];
			if (ctl_wr)
				hsel_ff <= CPU_WDATA[3];
			seen_ff <= !ctl_wr && (seen_ff || FRAME_START);
			gap_ff <= FRAME_START ? 13'h0000 : gap_ff + 13'h0001;
		end
	end

	////////////////////////////////
	property p_ack_after;
		(CPU_WR || CPU_RD) |=> CPU_ACK;
	endproperty
	a_ack_after: assert property (p_ack_after) else $error("no ack after strobe");
	property p_rd_hold;
		!CPU_RD |=> $stable(CPU_RDATA);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_unmapped;
		CPU_RD && CPU_ADDR[7:2] != 6'h03 |=> CPU_RDATA == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_fs_pulse;
		FRAME_START |=> !FRAME_START;
	endproperty
	a_fs_pulse: assert property (p_fs_pulse) else $error("frame pulse too long");
	property p_frame_len;
		FRAME_START && seen_ff |-> gap_ff == 13'h17ff;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
	property p_done;
		sel_go ##[2:3] abr_rd |=> CPU_RDATA[14] && CPU_RDATA[13:12] == 2'h0;
	endproperty
	a_done: assert property (p_done) else $error("transfer not complete");
	property p_cda_clr;
		sel_drop ##[1:3] abr_rd |=> !CPU_RDATA[14];
	endproperty
	a_cda_clr: assert property (p_cda_clr) else $error("completion not cleared");
	property p_high;
		CPU_RD && CPU_ADDR == 8'h0e && hsel_ff |=> CPU_RDATA[15:2] == 14'h0000;
	endproperty
	a_high: assert property (p_high) else $error("high part too wide");

	c_frame: cover property (FRAME_START);
	c_done: cover property (sel_go ##3 abr_rd);
	c_high: cover property (CPU_RD && hsel_ff);
endmodule

bind lcm_decode lcm_decode_chk u_chk (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .CPU_ADDR(CPU_ADDR),
	.CPU_WDATA(CPU_WDATA), .CPU_WR(CPU_WR), .CPU_RD(CPU_RD), .CPU_RDATA(CPU_RDATA), .CPU_ACK(CPU_ACK),
	.FRAME_START(FRAME_START));

/* sim/lcm_stream_far_end.sv */
// Far-end stream devices on the local and backplane buses.
// Assumes the bench flips polarity only between captures.
module lcm_stream_far_end (
	input logic flip,
	output logic [15:0] local_lines,
	output logic [31:0] back_lines
);
	// Steady lines make each switched byte all ones or all zeros whatever the slot phase.
	always_comb
	begin
		for (int k = 0; k < 16; k++)
			local_lines[k] = k[0] ^ flip; // Local source level.
		for (int k = 0; k < 32; k++)
			back_lines[k] = k[1] ^ flip; // Backplane source level.
	end
endmodule

/* sim/test_local_connection_memory_decode.sv */
// Self-checking bench for the local connection memory decoder.
// Assumes the checker is bound to the decoder and the far end holds steady levels.
module test_local_connection_memory_decode;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK_SYS = 1'b0;
	logic ARST_N = 1'b0;
	logic [7:0] CPU_ADDR = 8'h00;
	logic [15:0] CPU_WDATA = 16'h0000;
	logic CPU_WR = 1'b0;
	logic CPU_RD = 1'b0;
	logic [15:0] CPU_RDATA;
	logic CPU_ACK;
	logic [15:0] LOCAL_SERIAL_INPUTS;
	logic [31:0] BACKPLANE_SERIAL_LINES;
	logic [15:0] LOCAL_SERIAL_OUTPUTS;
	logic [15:0] LOCAL_SERIAL_OE;
	logic FRAME_START;
	logic flip = 1'b0;
	logic [31:0] seed = 32'h0000_0021;
	logic [15:0] rd;
	logic [15:0] hv;
	logic [15:0] ent [0:2047];
	logic prog [0:2047];
	logic [15:0] cap_d [0:1023];
	logic [15:0] cap_o [0:1023];
	logic [7:0] offs [0:7] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h00, 8'h0b, 8'h10, 8'hff};
	logic [15:0] corner [0:8] = '{16'hd800, 16'h3080, 16'h1f80, 16'hd200, 16'h3080, 16'h1780,
		16'h9600, 16'h9680, 16'h30a5};
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;

	lcm_decode u_dut (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .CPU_ADDR(CPU_ADDR), .CPU_WDATA(CPU_WDATA),
		.CPU_WR(CPU_WR), .CPU_RD(CPU_RD), .CPU_RDATA(CPU_RDATA), .CPU_ACK(CPU_ACK),
		.LOCAL_SERIAL_INPUTS(LOCAL_SERIAL_INPUTS), .BACKPLANE_SERIAL_LINES(BACKPLANE_SERIAL_LINES),
		.LOCAL_SERIAL_OUTPUTS(LOCAL_SERIAL_OUTPUTS), .LOCAL_SERIAL_OE(LOCAL_SERIAL_OE), .FRAME_START(FRAME_START));
	lcm_stream_far_end u_far (.flip(flip), .local_lines(LOCAL_SERIAL_INPUTS), .back_lines(BACKPLANE_SERIAL_LINES));

	////////////////////////////////
	// The clock toggles every 10 ns, a period of 20 ns.
	always #10 CLK_SYS = ~CLK_SYS;

	// Three passes need about twelve frames of 6144 cycles, so the ceiling leaves margin.
	always @(posedge CLK_SYS)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			mismatches++;
			report_and_stop();
		end
	end

	////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// Expected slot byte; a stream past the range of the rate gives the idle byte.
	function automatic logic [7:0] exp_byte(input logic [15:0] e, input logic [2:0] md, input logic f);
		logic [4:0] s;
		logic [4:0] lim;
		logic [7:0] b;
		s = e[11:7];
		if (e[13])
			return e[7:0]; // Message byte.
		if (e[15])
			lim = (md == 3'h2) ? 5'h03 : ((md == 3'h4) ? 5'h0c : 5'h0f); // Local range.
		else
			lim = (md == 3'h2) ? 5'h0f : 5'h1f; // Backplane range.
		b = (s > lim) ? 8'hff : {8{(e[15] ? s[0] : s[1]) ^ f}}; // Far-end level.
		return (md == 3'h4) ? {6'h3f, b[1:0]} : b; // Sub-rate pair with ones above.
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One register access: a one-cycle strobe, then a bounded wait for the ack.
	task automatic cpu(input logic wr, input logic [7:0] a, input logic [15:0] d);
		@(posedge CLK_SYS);
		CPU_ADDR <= a;
		CPU_WDATA <= d;
		CPU_WR <= wr;
		CPU_RD <= !wr;
		@(posedge CLK_SYS);
		CPU_WR <= 1'b0;
		CPU_RD <= 1'b0;
		for (int i = 0; i < 4 && CPU_ACK !== 1'b1; i++)
			@(posedge CLK_SYS);
		check({15'h0000, CPU_ACK}, 16'h0001); // Ack seen.
		rd = CPU_RDATA;
	endtask

	// Indirect access: raise a select, poll completion, drop the select, then fetch read data.
	task automatic mem(input logic wr, input logic [10:0] loc, input logic [15:0] d);
		logic [15:0] abr;
		abr = {4'h0, loc[6:0], 1'b0, loc[10:7]};
		if (wr)
			cpu(1'b1, 8'h0d, d);
		cpu(1'b1, 8'h0c, abr | (wr ? 16'h1000 : 16'h2000));
		rd = 16'h0000;
		for (int i = 0; i < 8 && rd[14] !== 1'b1; i++)
			cpu(1'b0, 8'h0c, 16'h0000);
		check(rd & 16'h7000, 16'h4000); // Done, select cleared.
		cpu(1'b1, 8'h0c, abr);
		cpu(1'b0, 8'h0c, 16'h0000);
		check(rd & 16'h7000, 16'h0000); // Completion cleared.
		if (!wr)
			cpu(1'b0, 8'h0e, 16'h0000);
	endtask

	task automatic wait_fs();
		@(posedge CLK_SYS);
		for (int i = 0; i < 7000 && FRAME_START !== 1'b1; i++)
			@(posedge CLK_SYS);
	endtask

	// Samples every output bit of one frame near mid-bit.
	task automatic cap(input int nch, input int div);
		repeat (div / 2) @(posedge CLK_SYS);
		for (int b = 0; b < nch * 8; b++)
		begin
			cap_d[b] = LOCAL_SERIAL_OUTPUTS;
			cap_o[b] = LOCAL_SERIAL_OE;
			repeat (div) @(posedge CLK_SYS);
		end
	endtask

	// One rate pass: corner and random entries, three frames to settle, then one captured frame.
	// The frame cut by a rate or level change leaves stale bytes in one bank, hence three.
	task automatic run_pass(input logic [2:0] md);
		logic [10:0] loc;
		logic [15:0] e;
		logic [7:0] got;
		int nch;
		nch = (md == 3'h2) ? 128 : 32;
		cpu(1'b1, 8'h0f, {13'h0000, md});
		foreach (prog[l])
			prog[l] = 1'b0;
		for (int i = 0; i < 40; i++)
		begin
			seed = xs(seed);
			e = (i < 3) ? corner[md * 3 / 2 + i] : seed[15:0];
			if (!e[13])
				e[6:0] = e[6:0] & 7'(nch - 1);
			loc = {seed[19:16] & ((md == 3'h2) ? 4'h3 : 4'hf), seed[26:20] & 7'(nch - 1)};
			mem(1'b1, loc, e); // Random delay mode too.
			mem(1'b0, loc, 16'h0000);
			check(rd, e); // Entry readback.
			ent[loc] = e;
			prog[loc] = 1'b1;
		end
		repeat (3) wait_fs();
		cap(nch, (md == 3'h2) ? 6 : 24);
		foreach (prog[l])
			if (prog[l])
			begin
				for (int k = 0; k < 8; k++)
					got[7 - k] = cap_d[l[6:0] * 8 + k][l[10:7]];
				check({15'h0000, cap_o[l[6:0] * 8][l[10:7]]}, {15'h0000, ent[l][12]}); // Enable.
				if (ent[l][12])
					check({8'h00, got}, {8'h00, exp_byte(ent[l], md, flip)}); // Byte.
			end
	endtask

	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	////////////////////////////////
	// Reset state, register reset values and unmapped reads, high part, then three rate passes.
	initial
	begin
		repeat (5) @(posedge CLK_SYS);
		check(LOCAL_SERIAL_OE, 16'h0000); // Drivers off in reset.
		check(LOCAL_SERIAL_OUTPUTS, 16'hffff);
		ARST_N <= 1'b1;
		foreach (offs[i])
		begin
			cpu(1'b0, offs[i], 16'h0000);
			check(rd, 16'h0000); // Reset or unmapped value.
		end
		cpu(1'b1, 8'h0f, 16'h0008);
		for (int k = 0; k < 5; k++)
		begin
			hv = 16'((3 - k) & 3);
			mem(1'b1, 11'h085, hv); // Upper bits kept zero.
			mem(1'b0, 11'h085, 16'h0000);
			check(rd, hv & 16'h0003); // Pair select code.
		end
		run_pass(3'h0);
		flip <= 1'b1;
		run_pass(3'h2);
		flip <= 1'b0;
		run_pass(3'h4);
		report_and_stop();
	end
endmodule
